//--- rtl/bit_field_execution_unit.v
`timescale 1ns/1ps
`include "bit_field_regs.vh"

// Notes on behaviour
// (RL1) Field is up to 32 consecutive bits, ignoring byte boundaries.
// (RL2) Signed offset counts from the MSB of the byte at the address.
// (RL3) Width must lie between one and thirty-two inclusive.
// (RL4) Field bit zero is its most significant bit.
// (RL5) Insert writes source low bits into field, rest untouched.
// (RL6) Signed extract right-justifies field and replicates its top bit.
// (RL7) Unsigned extract right-justifies field and zero fills above.
// (RL8) Set writes ones into every field bit.
// (RL9) Clear writes zeros into every field bit.
// (RL10) Change inverts every field bit.
// (RL11) Set, clear, change take flags from the field before change.
// (RL12) Test sets flags from field and never writes it.
// (RL13) Find-first-one scans from field MSB, returns offset of one.
// (RL14) With no one found, returns offset plus width.
// (RL15) Pipeline sync stalls until outstanding bus cycles finish.
// (RL16) Pipeline sync starts after integer and external FP accesses end.
// (RL17) Pipeline sync ignores FP ops writing FP registers.
// (RL18) Flags: N from field MSB, Z if field zero, V and C clear.
module bit_field_execution_unit (
  input wire mclk,
  input wire rst,
  input wire op_valid,
  output wire op_ready,
  input wire [3:0] op_code,
  input wire op_mem,
  input wire [31:0] op_ea,
  input wire [31:0] op_offset,
  input wire [5:0] op_width,
  input wire [31:0] op_src,
  input wire [31:0] op_dreg,
  input wire int_pending,
  input wire fp_ext_pending,
  input wire bus_pending,
  output wire mem_req,
  output wire mem_we,
  output wire mem_lock,
  output reg [31:0] mem_addr_q,
  output reg [31:0] mem_wdata_q,
  input wire [31:0] mem_rdata,
  input wire mem_ack,
  output reg res_valid_q,
  output reg [31:0] res_data_q,
  output reg res_wr_q,
  output reg res_cc_we_q,
  output reg res_error_q,
  output reg cc_n_q,
  output reg cc_z_q,
  output reg cc_v_q,
  output reg cc_c_q
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_RD0 = 9'h002;
  localparam [8:0] S_RD1 = 9'h004;
  localparam [8:0] S_MOD = 9'h008;
  localparam [8:0] S_WR0 = 9'h010;
  localparam [8:0] S_WR1 = 9'h020;
  localparam [8:0] S_PRE = 9'h040;
  localparam [8:0] S_BUS = 9'h080;
  localparam [8:0] S_DONE = 9'h100;

  reg [8:0] state_q;
  reg [3:0] op_q;
  reg mem_q;
  reg [31:0] off_q;
  reg [5:0] width_q;
  reg [5:0] start_q;
  reg [31:0] src_q;
  reg [31:0] dreg_q;
  reg [31:0] adr_q;
  reg need2_q;
  reg err_q;
  reg [63:0] win_q;

  wire [31:0] byte_adr;
  wire [5:0] start_mem;
  wire [6:0] span;
  wire width_bad;
  wire [31:0] ext;
  wire [63:0] mask;
  wire [63:0] new_win;
  wire [5:0] first_one;
  wire fz;
  wire fmsb;
  wire iz;
  wire imsb;
  wire [31:0] reg_new;

  // Ops that write the field back
  function is_modify;
    input [3:0] op;
    begin
      is_modify = (op == `BF_OP_INSERT) || (op == `BF_OP_SET) ||
        (op == `BF_OP_CLEAR) || (op == `BF_OP_INVERT);
    end
  endfunction

  // ----------------------------------------
  // Field addressing
  // ----------------------------------------
  // (RL2) Signed offset from byte MSB
  assign byte_adr = op_ea + {{3{op_offset[31]}}, op_offset[31:3]};
  // (RL1) Field may straddle two words
  assign start_mem = {1'b0, byte_adr[1:0], op_offset[2:0]};
  assign span = {1'b0, start_mem} + {1'b0, op_width};
  // (RL3) Width one to thirty-two
  assign width_bad = (op_width == 6'h00) || (op_width > `BF_WIDTH_MAX);

  field_window_kernel u_kernel (
    .win(win_q),
    .start(start_q),
    .width(width_q),
    .op(op_q),
    .src(src_q),
    .ext(ext),
    .mask(mask),
    .new_win(new_win),
    .first_one(first_one),
    .fz(fz),
    .fmsb(fmsb),
    .iz(iz),
    .imsb(imsb)
  );

  // Register operand wraps: fold both window halves back onto one word
  assign reg_new = (new_win[63:32] & mask[63:32]) |
    (new_win[31:0] & mask[31:0]) |
    (dreg_q & ~(mask[63:32] | mask[31:0]));

  // ----------------------------------------
  // Handshakes
  // ----------------------------------------
  assign op_ready = (state_q == S_IDLE);
  assign mem_req = (state_q == S_RD0) || (state_q == S_RD1) ||
    (state_q == S_WR0) || (state_q == S_WR1);
  // (RL12) Writes only for modify ops
  assign mem_we = (state_q == S_WR0) || (state_q == S_WR1);
  // Lock keeps read-modify-write indivisible on a shared bus
  assign mem_lock = mem_q && is_modify(op_q) && (state_q != S_IDLE) &&
    (state_q != S_DONE);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= S_IDLE;
      op_q <= `BF_OP_TEST;
      mem_q <= 1'b0;
      off_q <= `BF_WORD_RST;
      width_q <= `BF_WIDTH_MAX;
      start_q <= 6'h00;
      src_q <= `BF_WORD_RST;
      dreg_q <= `BF_WORD_RST;
      adr_q <= `BF_WORD_RST;
      need2_q <= 1'b0;
      err_q <= 1'b0;
      win_q <= `BF_WIN_RST;
      mem_addr_q <= `BF_WORD_RST;
      mem_wdata_q <= `BF_WORD_RST;
      res_valid_q <= 1'b0;
      res_data_q <= `BF_WORD_RST;
      res_wr_q <= 1'b0;
      res_cc_we_q <= 1'b0;
      res_error_q <= 1'b0;
      cc_n_q <= 1'b0;
      cc_z_q <= 1'b0;
      cc_v_q <= 1'b0;
      cc_c_q <= 1'b0;
    end
    else
    begin
      res_valid_q <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          if (op_valid)
          begin
            op_q <= op_code;
            mem_q <= op_mem;
            off_q <= op_offset;
            width_q <= op_width;
            src_q <= op_src;
            dreg_q <= op_dreg;
            adr_q <= {byte_adr[31:2], 2'b00};
            need2_q <= (span > `BF_SPAN_LIMIT);
            err_q <= 1'b0;
            if (op_mem)
            begin
              start_q <= start_mem;
              win_q <= `BF_WIN_RST;
            end
            else
            begin
              start_q <= {1'b0, op_offset[4:0]};
              win_q <= {op_dreg, op_dreg};
            end
            if (op_code == `BF_OP_SYNC)
              state_q <= S_PRE;
            else if (width_bad || (op_code > `BF_OP_FFO))
            begin
              err_q <= 1'b1;
              state_q <= S_DONE;
            end
            else if (op_mem)
            begin
              mem_addr_q <= {byte_adr[31:2], 2'b00};
              state_q <= S_RD0;
            end
            else
              state_q <= S_DONE;
          end
        end
        S_RD0:
        begin
          if (mem_ack)
          begin
            win_q[63:32] <= mem_rdata;
            if (need2_q)
            begin
              mem_addr_q <= adr_q + `BF_WORD_STEP;
              state_q <= S_RD1;
            end
            else if (is_modify(op_q))
              state_q <= S_MOD;
            else
              state_q <= S_DONE;
          end
        end
        S_RD1:
        begin
          if (mem_ack)
          begin
            win_q[31:0] <= mem_rdata;
            if (is_modify(op_q))
              state_q <= S_MOD;
            else
              state_q <= S_DONE;
          end
        end
        S_MOD:
        begin
          mem_addr_q <= adr_q;
          mem_wdata_q <= new_win[63:32];
          state_q <= S_WR0;
        end
        S_WR0:
        begin
          if (mem_ack)
          begin
            if (need2_q)
            begin
              mem_addr_q <= adr_q + `BF_WORD_STEP;
              mem_wdata_q <= new_win[31:0];
              state_q <= S_WR1;
            end
            else
              state_q <= S_DONE;
          end
        end
        S_WR1:
        begin
          if (mem_ack)
            state_q <= S_DONE;
        end
        S_PRE:
        begin
          // (RL16) Earlier work drained first
          // (RL17) FP register ops not awaited
          if (!int_pending && !fp_ext_pending)
            state_q <= S_BUS;
        end
        S_BUS:
        begin
          // (RL15) Wait for bus idle
          if (!bus_pending)
            state_q <= S_DONE;
        end
        S_DONE:
        begin
          state_q <= S_IDLE;
          res_valid_q <= 1'b1;
          res_error_q <= err_q;
          res_wr_q <= 1'b0;
          res_cc_we_q <= 1'b0;
          if (!err_q && (op_q != `BF_OP_SYNC))
          begin
            res_cc_we_q <= 1'b1;
            cc_v_q <= 1'b0;
            cc_c_q <= 1'b0;
            // (RL11) Flags from prior value
            cc_n_q <= fmsb;
            cc_z_q <= fz;
            case (op_q)
              `BF_OP_INSERT:
              begin
                cc_n_q <= imsb;
                cc_z_q <= iz;
                res_data_q <= reg_new;
                res_wr_q <= !mem_q;
              end
              `BF_OP_EXT_SIGNED, `BF_OP_EXT_UNSIGNED:
              begin
                res_data_q <= ext;
                res_wr_q <= 1'b1;
              end
              `BF_OP_FFO:
              begin
                // (RL14) Offset plus index
                res_data_q <= off_q + {26'h0, first_one};
                res_wr_q <= 1'b1;
              end
              `BF_OP_SET, `BF_OP_CLEAR, `BF_OP_INVERT:
              begin
                res_data_q <= reg_new;
                res_wr_q <= !mem_q;
              end
              default:
              begin
                res_data_q <= res_data_q;
              end
            endcase
          end
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule

//--- include/bit_field_regs.vh
`ifndef BIT_FIELD_REGS_VH
`define BIT_FIELD_REGS_VH

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define BF_OP_INSERT 4'h0
`define BF_OP_EXT_SIGNED 4'h1
`define BF_OP_EXT_UNSIGNED 4'h2
`define BF_OP_SET 4'h3
`define BF_OP_CLEAR 4'h4
`define BF_OP_INVERT 4'h5
`define BF_OP_TEST 4'h6
`define BF_OP_FFO 4'h7
`define BF_OP_SYNC 4'h8

// ----------------------------------------
// Field geometry and reset values
// ----------------------------------------
`define BF_WIDTH_MAX 6'h20
`define BF_SPAN_LIMIT 7'h20
`define BF_WORD_STEP 32'h00000004
`define BF_WORD_RST 32'h00000000
`define BF_WIN_RST 64'h0000000000000000

`endif

//--- rtl/field_window_kernel.v
`timescale 1ns/1ps
`include "bit_field_regs.vh"

// ----------------------------------------
// Field operations on a 64-bit big-endian window
// ----------------------------------------
module field_window_kernel (
  input wire [63:0] win,
  input wire [5:0] start,
  input wire [5:0] width,
  input wire [3:0] op,
  input wire [31:0] src,
  output wire [31:0] ext,
  output wire [63:0] mask,
  output reg [63:0] new_win,
  output wire [5:0] first_one,
  output wire fz,
  output wire fmsb,
  output wire iz,
  output wire imsb
);

  wire [63:0] shl;
  wire [31:0] top;
  wire [31:0] tmask;
  wire [31:0] lmask;
  wire [31:0] field;
  wire [31:0] ins_top;
  wire [63:0] ins64;
  wire [5:0] rshift;

  // Index of the first one from the most significant end, 32 if none
  function [5:0] lead_one;
    input [31:0] v;
    integer i;
    begin
      lead_one = 6'h20;
      for (i = 0; i < 32; i = i + 1)
      begin
        if (v[i])
          lead_one = 6'h1f - i[5:0];
      end
    end
  endfunction

  // (RL4) MSB-first numbering
  assign shl = win << start;
  assign top = shl[63:32];
  assign tmask = ~(32'hffffffff >> width);
  assign lmask = ~(32'hffffffff << width);
  assign rshift = `BF_WIDTH_MAX - width;
  assign field = top >> rshift;
  assign mask = {tmask, 32'h00000000} >> start;
  assign ins_top = src << rshift;
  assign ins64 = {ins_top, 32'h00000000} >> start;

  // (RL18) Flags from field value
  assign fmsb = top[31];
  assign fz = ((top & tmask) == 32'h00000000);
  assign iz = ((src & lmask) == 32'h00000000);
  assign imsb = ins_top[31];

  // (RL6) Sign replication
  // (RL7) Zero fill
  assign ext = (op == `BF_OP_EXT_SIGNED && fmsb) ? (field | ~lmask) : field;

  // (RL13) Scan from bit zero
  // (RL14) Width when empty
  assign first_one = fz ? width : lead_one(top & tmask);

  always @*
  begin
    case (op)
      // (RL5) Insert low bits
      `BF_OP_INSERT: new_win = (win & ~mask) | ins64;
      // (RL8) Set all ones
      `BF_OP_SET: new_win = win | mask;
      // (RL9) Clear all bits
      `BF_OP_CLEAR: new_win = win & ~mask;
      // (RL10) Invert field bits
      `BF_OP_INVERT: new_win = win ^ mask;
      default: new_win = win;
    endcase
  end

endmodule

//--- tb/field_memory_model.sv
`timescale 1ns/1ps
module field_memory_model (
  input wire mclk,
  input wire rst,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr_q,
  input wire [31:0] mem_wdata_q,
  input wire [1:0] stall,
  output reg [31:0] mem_rdata,
  output reg mem_ack
);
  reg [31:0] mem [0:3];
  reg [1:0] wait_q;
  // Data off the ack cycle is scrambled so stale reads show up
  always @(posedge mclk)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (rst)
    begin
      wait_q <= 2'h0;
      mem_rdata <= 32'h00000000;
    end
    else if (mem_req && !mem_ack)
    begin
      if (wait_q != stall)
        wait_q <= wait_q + 2'h1;
      else
      begin
        mem_ack <= 1'b1;
        wait_q <= 2'h0;
        if (mem_we)
          mem[mem_addr_q[3:2]] <= mem_wdata_q;
        else
          mem_rdata <= mem[mem_addr_q[3:2]];
      end
    end
  end
endmodule

//--- tb/bit_field_execution_unit_properties.sv
`timescale 1ns/1ps
`include "bit_field_regs.vh"
module bit_field_execution_unit_properties (
  input wire mclk,
  input wire rst,
  input wire op_valid,
  input wire op_ready,
  input wire [3:0] op_code,
  input wire op_mem,
  input wire [5:0] op_width,
  input wire int_pending,
  input wire fp_ext_pending,
  input wire bus_pending,
  input wire mem_req,
  input wire mem_we,
  input wire mem_lock,
  input wire [31:0] mem_addr_q,
  input wire mem_ack,
  input wire res_valid_q,
  input wire res_wr_q,
  input wire res_cc_we_q,
  input wire res_error_q,
  input wire cc_v_q,
  input wire cc_c_q
);
  reg ro_q;
  reg sync_q;
  wire take = op_valid && op_ready;
  wire bad_w = op_width == 6'h00 || op_width > `BF_WIDTH_MAX;
  wire bad = op_code > `BF_OP_SYNC || (op_code != `BF_OP_SYNC && bad_w);
  // Kind of op in flight, kept until the next take
  always @(posedge mclk)
  begin
    if (rst)
    begin
      ro_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else if (take)
    begin
      ro_q <= op_code == 4'h1 || op_code == 4'h2 || op_code >= 4'h6;
      sync_q <= op_code == `BF_OP_SYNC;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence reg_take;
    take && !op_mem && op_code != `BF_OP_SYNC;
  endsequence
  sequence reg_finish;
    !op_ready ##1 res_valid_q;
  endsequence
  sequence quiet_error;
    !mem_req ##1 (res_valid_q && res_error_q && !res_wr_q && !res_cc_we_q);
  endsequence
  a_reg_latency: assert property (reg_take |=> reg_finish)
    else $error("register op result late");
  a_illegal_quiet: assert property (take && bad |=> quiet_error)
    else $error("illegal op not refused");
  a_req_stable: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr_q) && $stable(mem_we))
    else $error("bus request changed before ack");
  a_readonly_nowrite: assert property (ro_q && mem_req |-> !mem_we)
    else $error("write cycle from read-only op");
  a_write_locked: assert property (mem_req && mem_we |-> mem_lock)
    else $error("write outside locked cycle");
  a_sync_stall: assert property (sync_q &&
    (int_pending || fp_ext_pending || bus_pending) |=> !res_valid_q)
    else $error("sync finished while work pending");
  a_sync_flags: assert property (sync_q && res_valid_q |->
    !res_cc_we_q && !res_wr_q)
    else $error("sync result wrote flags or register");
  a_vc_cleared: assert property (res_valid_q && res_cc_we_q |->
    !cc_v_q && !cc_c_q)
    else $error("overflow or carry left set");
endmodule
bind bit_field_execution_unit bit_field_execution_unit_properties u_props (
  .mclk(mclk), .rst(rst), .op_valid(op_valid), .op_ready(op_ready),
  .op_code(op_code), .op_mem(op_mem), .op_width(op_width),
  .int_pending(int_pending), .fp_ext_pending(fp_ext_pending),
  .bus_pending(bus_pending), .mem_req(mem_req), .mem_we(mem_we),
  .mem_lock(mem_lock), .mem_addr_q(mem_addr_q), .mem_ack(mem_ack),
  .res_valid_q(res_valid_q), .res_wr_q(res_wr_q),
  .res_cc_we_q(res_cc_we_q), .res_error_q(res_error_q),
  .cc_v_q(cc_v_q), .cc_c_q(cc_c_q));

//--- tb/testbench.sv
`timescale 1ns/1ps
`include "bit_field_regs.vh"
module testbench;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg op_valid = 1'b0;
  reg op_mem = 1'b0;
  reg int_pending = 1'b0;
  reg fp_ext_pending = 1'b0;
  reg bus_pending = 1'b0;
  reg [3:0] op_code = 4'h0;
  reg [5:0] op_width = 6'h01;
  reg [1:0] stall = 2'h0;
  reg [31:0] op_ea = 32'h00000000;
  reg [31:0] op_offset = 32'h00000000;
  reg [31:0] op_src = 32'h00000000;
  reg [31:0] op_dreg = 32'h00000000;
  wire op_ready, mem_req, mem_we, mem_lock, mem_ack, res_valid_q;
  wire res_wr_q, res_cc_we_q, res_error_q, cc_n_q, cc_z_q, cc_v_q, cc_c_q;
  wire [31:0] mem_addr_q, mem_wdata_q, mem_rdata, res_data_q;
  integer err_count = 0;
  integer compares = 0;
  integer seed = 32'h0b4a46ea;
  integer i, k;
  reg [63:0] w, nw, f;
  reg [31:0] a, xd;
  reg [6:0] s;
  reg [5:0] idx;
  reg wrx;
  always #5 mclk = ~mclk;
  bit_field_execution_unit dut (
    .mclk(mclk), .rst(rst), .op_valid(op_valid), .op_ready(op_ready),
    .op_code(op_code), .op_mem(op_mem), .op_ea(op_ea),
    .op_offset(op_offset), .op_width(op_width), .op_src(op_src),
    .op_dreg(op_dreg), .int_pending(int_pending),
    .fp_ext_pending(fp_ext_pending), .bus_pending(bus_pending),
    .mem_req(mem_req), .mem_we(mem_we), .mem_lock(mem_lock),
    .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .res_valid_q(res_valid_q),
    .res_data_q(res_data_q), .res_wr_q(res_wr_q),
    .res_cc_we_q(res_cc_we_q), .res_error_q(res_error_q),
    .cc_n_q(cc_n_q), .cc_z_q(cc_z_q), .cc_v_q(cc_v_q), .cc_c_q(cc_c_q));
  field_memory_model u_mem (
    .mclk(mclk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .stall(stall),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  task report_and_stop;
    begin
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task check(input [63:0] seen, input [63:0] exp, input [39:0] nm);
    begin
      compares = compares + 1;
      if (seen !== exp)
      begin
        err_count = err_count + 1;
        $display("MISMATCH %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // Pending inputs drop after eight cycles to release a sync
  task issue;
    begin
      op_valid = 1'b1;
      @(posedge mclk);
      #1 op_valid = 1'b0;
      k = 0;
      while (res_valid_q !== 1'b1 && k < 300)
      begin
        @(posedge mclk);
        #1 k = k + 1;
        if (k == 8)
          {int_pending, fp_ext_pending, bus_pending} = 3'h0;
      end
      if (k == 300)
      begin
        err_count = err_count + 1;
        report_and_stop;
      end
    end
  endtask
  // Field of width op_width at bit p of a big-endian window
  function [63:0] fmask(input [6:0] p);
    fmask = ((64'h1 << op_width) - 64'h1) << (7'h40 - p - op_width);
  endfunction
  function [63:0] fmod(input [63:0] v, input [6:0] p);
    reg [63:0] m;
    begin
      m = fmask(p);
      case (op_code)
        `BF_OP_INSERT: fmod = (v & ~m) |
          (({32'h0, op_src} << (7'h40 - p - op_width)) & m);
        `BF_OP_SET: fmod = v | m;
        `BF_OP_CLEAR: fmod = v & ~m;
        `BF_OP_INVERT: fmod = v ^ m;
        default: fmod = v;
      endcase
    end
  endfunction
  initial
  begin
    repeat (6) @(posedge mclk);
    #1 rst = 1'b0;
    for (i = 0; i < 320; i = i + 1)
    begin
      op_code = i % 8;
      op_mem = (i / 8) % 2;
      op_width = (i % 5 == 0) ? 6'h20 : ($random(seed) & 31) + 1;
      op_src = $random(seed);
      op_dreg = (i % 7 == 0) ? 32'h0 : $random(seed);
      op_offset = op_mem ? $random(seed) % 16 : $random(seed);
      op_ea = 4 + ($random(seed) & 3);
      stall = $random(seed);
      for (k = 0; k < 4; k = k + 1)
        u_mem.mem[k] = (i % 7 == 0) ? 32'h0 : $random(seed);
      // Window is read before the op may rewrite it
      if (op_mem)
      begin
        a = $signed(op_ea) + ($signed(op_offset) >>> 3);
        s = {a[1:0], 3'h0} + op_offset[2:0];
        w = {u_mem.mem[a[3:2]], u_mem.mem[a[3:2] + 2'h1]};
      end
      else
      begin
        s = 7'h0;
        w = {op_dreg, op_dreg} << op_offset[4:0];
      end
      f = (w & fmask(s)) >> (7'h40 - s - op_width);
      nw = fmod(w, s);
      idx = op_width;
      for (k = 1; k <= op_width; k = k + 1)
        if (f[k - 1])
          idx = op_width - k;
      issue;
      xd = {nw[63:32], nw[63:32]} >> op_offset[4:0];
      if (op_code == 4'h1)
        xd = f | (f[op_width - 1] ? ~((64'h1 << op_width) - 64'h1) : 0);
      if (op_code == 4'h2)
        xd = f;
      if (op_code == 4'h7)
        xd = op_offset + idx;
      if (op_code == 4'h0)
        f = op_src & ((64'h1 << op_width) - 64'h1);
      wrx = op_code == 1 || op_code == 2 || op_code == 7;
      wrx = wrx || (!op_mem && op_code != 6);
      if (wrx)
        check(res_data_q, xd, "data");
      check({res_wr_q, res_cc_we_q, res_error_q}, {wrx, 2'b10}, "ctl");
      check({cc_n_q, cc_z_q, cc_v_q, cc_c_q},
        {f[op_width - 1], f == 0, 2'b00}, "cc");
      if (op_mem)
        check({u_mem.mem[a[3:2]], u_mem.mem[a[3:2] + 2'h1]}, nw, "mem");
    end
    for (i = 9; i < 18; i = i + 1)
    begin
      op_code = i < 16 ? i : 1;
      op_width = i == 16 ? 6'h00 : i == 17 ? 6'h21 : 6'h05;
      op_mem = i % 2;
      issue;
      check({res_wr_q, res_cc_we_q, res_error_q}, 3'b001, "err");
    end
    for (i = 0; i < 4; i = i + 1)
    begin
      op_code = `BF_OP_SYNC;
      op_width = 6'h01;
      {int_pending, fp_ext_pending, bus_pending} = 3'h4 >> i;
      issue;
      check(k > 8, i < 3, "sync");
      check({res_wr_q, res_cc_we_q}, 2'b00, "syncf");
    end
    report_and_stop;
  end
endmodule
